// ===== design/rail_cfg_pkg.sv
package rail_cfg_pkg;

  // ----------------------------------------------------------------
  // Command codes of the page 0 configuration block
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RAIL_ONE_CONFIG_THREE      = 8'h44;
  localparam logic [7:0] CMD_SHED_EXIT_CTRL             = 8'h45;
  localparam logic [7:0] CMD_SHED_EXIT_LIMIT_ONE_TWO    = 8'h46;
  localparam logic [7:0] CMD_SHED_EXIT_LIMIT_THREE_FOUR = 8'h47;
  localparam logic [7:0] CMD_SHED_EXIT_LIMIT_FIVE_SIX   = 8'h48;
  localparam logic [7:0] CMD_SHED_EXIT_LIMIT_SEVEN      = 8'h49;
  localparam logic [7:0] CMD_OVERCURRENT_WARNING_LIMIT  = 8'h4a;
  localparam logic [7:0] CMD_CURRENT_REPORT_GAIN        = 8'h4d;

  // ----------------------------------------------------------------
  // Writable bits of each register; all other bits read as zero
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_CONFIG_THREE = 16'h03ff;
  localparam logic [15:0] MASK_SHED_CTRL    = 16'h0fff;
  localparam logic [15:0] MASK_FULL_WORD    = 16'hffff;
  localparam logic [15:0] MASK_LIMIT_SEVEN  = 16'h00ff;
  localparam logic [15:0] MASK_OCW_LIMIT    = 16'h01ff;
  localparam logic [15:0] MASK_REPORT_GAIN  = 16'h07ff;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CONFIG_THREE = 16'h0000;
  localparam logic [15:0] RST_SHED_CTRL    = 16'h0000;
  localparam logic [15:0] RST_LIMIT        = 16'h0000;
  localparam logic [15:0] RST_OCW_LIMIT    = 16'h01ff;
  localparam logic [15:0] RST_REPORT_GAIN  = 16'h0400;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_ALERT_ON_OCW   = 9;
  localparam int CFG_COUPLED_ON     = 7;
  localparam int CFG_SLEEP_SAVING   = 6;
  localparam int CFG_OFF_MODE_HI    = 5;
  localparam int CFG_OFF_MODE_LO    = 4;
  localparam int CFG_DELAY_TICK_SEL = 3;
  localparam int CTL_SINGLE_EXIT_ON = 11;
  localparam int CTL_MULTI_EXIT_ON  = 10;
  localparam int GAIN_SHIFT         = 10;

  // ----------------------------------------------------------------
  // Timing, clock is 10 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int TICK_FAST_NS    = 20000;  // 50 kHz delay tick
  localparam int TICK_SLOW_NS    = 50000;  // 20 kHz delay tick
  localparam int HOLD_LSB_NS     = 20000;  // Full-phase hold step
  localparam int TICK_FAST_CYC   = TICK_FAST_NS / CLK_PERIOD_NS;
  localparam int TICK_SLOW_CYC   = TICK_SLOW_NS / CLK_PERIOD_NS;
  localparam int HOLD_LSB_CYC    = HOLD_LSB_NS / CLK_PERIOD_NS;

  // Shutdown modes on enable low
  typedef enum logic [1:0] {
    OFF_HIZ       = 2'b00,
    OFF_SOFT_SLOW = 2'b01,
    OFF_SOFT_FAST = 2'b10,
    OFF_SOFT_BUS  = 2'b11
  } off_mode_e;

  // Measurement results from the pulse timing front end
  typedef struct packed {
    logic       offValid;   // One-cycle strobe
    logic [9:0] offTime;    // First phase off time less minimum, 10 ns units
    logic       gapValid;   // One-cycle strobe
    logic [9:0] gapTime;    // Phase to phase rising interval, 5 ns units
  } shed_meas_s;

endpackage

// ===== design/rail_config_shed_exit_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Config bit 7 turns coupled-inductor operation off (0) or on (1).
// - Low-power bit set and both enables low switches nonvolatile store off.
// - Low-power bit clear keeps store and command port live; enable gates power only.
// - Bits 5:4 pick shutdown: high-Z, slow soft-off, fast soft-off, bus-slew soft-off.
// - Bit 3 picks delay tick: 0 gives 50 kHz, 1 gives 20 kHz.
// - Unity gain window codes 100/010/001 give 300/220/140 mV; others invalid.
// - Half gain window codes give 600/440/280 mV above and below reference.
// - Control bit 11 enables exit from shedding on first phase off time.
// - Control bit 10 enables exit from shedding on phase-to-phase interval.
// - Bits 9:7 set consecutive off-time hits needed; reaching it exits at once.
// - After exit, run all phases at least bits 6:3 times 20 us.
// - Bits 2:0 set consecutive interval hits needed; reaching it exits at once.
// - Single phase: off time below low-byte limit bumps the exit counter.
// - Two phase: interval below high-byte limit bumps the exit counter.
// - Three and four phase limits are low and high bytes of next register.
// - Next register serves five/six phase rail 1, three/two phase rail 2.
// - Eight-bit limit serves seven phase rail 1 and single phase rail 2.
// - Current above warning limit sets status word bit 14 and current bit 5.
// - Warning also drives power alert low only when config bit 9 is set.
// - Report gain times monitor sample, divided by 1024, is reported current.
// - Reserved bits ignore writes and read as zero.
// - Turn-off wait counts delay ticks from enable low to soft shutdown.
module rail_config_shed_exit_regs (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              cmdCode,
  input  wire logic                    cmdWrite,
  input  wire logic [15:0]             cmdWrData,
  input  wire logic                    cmdRead,
  output logic      [15:0]             cmdRdData_q,
  output logic                         cmdRdValid_q,
  input  wire logic [1:0]              enablePin,
  input  wire logic [15:0]             turnOffWait,
  input  wire logic                    senseHalfGain,
  input  wire logic [2:0]              railOnePhases,
  input  wire logic [1:0]              railTwoPhases,
  input  wire rail_cfg_pkg::shed_meas_s shedMeas,
  input  wire logic                    monitorValid,
  input  wire logic [11:0]             monitorSample,
  input  wire logic                    ocwClear,
  output logic                         coupledInductorOn_q,
  output logic                         nvStoreOn_q,
  output logic                         commandPortOn_q,
  output logic                         railPowerOn_q,
  output logic                         hiZOff_q,
  output logic                         softOffStart_q,
  output logic [1:0]                   softOffSlew_q,
  output logic [9:0]                   voltWindowMv_q,
  output logic                         voltWindowValid_q,
  output logic                         forceFullPhase_q,
  output logic [7:0]                   railTwoGapLimit_q,
  output logic [12:0]                  reportCurrent_q,
  output logic                         statusWordOcw_q,
  output logic                         statusIoutOcw_q,
  output logic                         power_alert_n_q
);
  import rail_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] cfgThree_q, shedCtrl_q, limOneTwo_q, limThreeFour_q;
  logic [15:0] limFiveSix_q, limSeven_q, ocwLimit_q, gain_q;

  // Each write is masked so reserved bits never store
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfgThree_q     <= RST_CONFIG_THREE;
      shedCtrl_q     <= RST_SHED_CTRL;
      limOneTwo_q    <= RST_LIMIT;
      limThreeFour_q <= RST_LIMIT;
      limFiveSix_q   <= RST_LIMIT;
      limSeven_q     <= RST_LIMIT;
      ocwLimit_q     <= RST_OCW_LIMIT;
      gain_q         <= RST_REPORT_GAIN;
    end else if (cmdWrite) begin
      unique case (cmdCode)
        CMD_RAIL_ONE_CONFIG_THREE:      cfgThree_q     <= cmdWrData & MASK_CONFIG_THREE;
        CMD_SHED_EXIT_CTRL:             shedCtrl_q     <= cmdWrData & MASK_SHED_CTRL;
        CMD_SHED_EXIT_LIMIT_ONE_TWO:    limOneTwo_q    <= cmdWrData & MASK_FULL_WORD;
        CMD_SHED_EXIT_LIMIT_THREE_FOUR: limThreeFour_q <= cmdWrData & MASK_FULL_WORD;
        CMD_SHED_EXIT_LIMIT_FIVE_SIX:   limFiveSix_q   <= cmdWrData & MASK_FULL_WORD;
        CMD_SHED_EXIT_LIMIT_SEVEN:      limSeven_q     <= cmdWrData & MASK_LIMIT_SEVEN;
        CMD_OVERCURRENT_WARNING_LIMIT:  ocwLimit_q     <= cmdWrData & MASK_OCW_LIMIT;
        CMD_CURRENT_REPORT_GAIN:        gain_q         <= cmdWrData & MASK_REPORT_GAIN;
        default: ;
      endcase
    end
  end

  // Read selection; unknown codes answer zero
  logic [15:0] rdSel;
  assign rdSel = (cmdCode == CMD_RAIL_ONE_CONFIG_THREE)      ? cfgThree_q     :
                 (cmdCode == CMD_SHED_EXIT_CTRL)             ? shedCtrl_q     :
                 (cmdCode == CMD_SHED_EXIT_LIMIT_ONE_TWO)    ? limOneTwo_q    :
                 (cmdCode == CMD_SHED_EXIT_LIMIT_THREE_FOUR) ? limThreeFour_q :
                 (cmdCode == CMD_SHED_EXIT_LIMIT_FIVE_SIX)   ? limFiveSix_q   :
                 (cmdCode == CMD_SHED_EXIT_LIMIT_SEVEN)      ? limSeven_q     :
                 (cmdCode == CMD_OVERCURRENT_WARNING_LIMIT)  ? ocwLimit_q     :
                 (cmdCode == CMD_CURRENT_REPORT_GAIN)        ? gain_q         : 16'h0000;

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmdRdData_q  <= 16'h0000;
      cmdRdValid_q <= 1'b0;
    end else begin
      cmdRdData_q  <= cmdRead ? rdSel : 16'h0000;
      cmdRdValid_q <= cmdRead;
    end
  end

  // ----------------------------------------------------------------
  // Enable pin synchroniser
  // ----------------------------------------------------------------
  // Stage one feeds only stage two; a level counts once stages two and three agree
  logic [1:0] enMeta_q, enSync_q, enLate_q, enStable_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enMeta_q   <= 2'b00;
      enSync_q   <= 2'b00;
      enLate_q   <= 2'b00;
      enStable_q <= 2'b00;
    end else begin
      enMeta_q   <= enablePin;
      enSync_q   <= enMeta_q;
      enLate_q   <= enSync_q;
      enStable_q <= (enSync_q & ~(enSync_q ^ enLate_q)) | (enStable_q & (enSync_q ^ enLate_q));
    end
  end

  // ----------------------------------------------------------------
  // Mode bits and power state
  // ----------------------------------------------------------------
  logic       sleepNow;
  off_mode_e  offMode;
  assign sleepNow = cfgThree_q[CFG_SLEEP_SAVING] && (enStable_q == 2'b00);
  assign offMode  = off_mode_e'(cfgThree_q[CFG_OFF_MODE_HI:CFG_OFF_MODE_LO]);

  // Store and port stay up in regular mode; only deep sleep drops the store, and the port never drops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      coupledInductorOn_q <= 1'b0;
      nvStoreOn_q         <= 1'b1;
      commandPortOn_q     <= 1'b1;
    end else begin
      coupledInductorOn_q <= cfgThree_q[CFG_COUPLED_ON];
      nvStoreOn_q         <= !sleepNow;
      commandPortOn_q     <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Voltage window decode
  // ----------------------------------------------------------------
  logic [9:0] windowMv;
  logic       windowOk;
  assign windowMv = (cfgThree_q[2:0] == 3'b100) ? (senseHalfGain ? 10'd600 : 10'd300) :
                    (cfgThree_q[2:0] == 3'b010) ? (senseHalfGain ? 10'd440 : 10'd220) :
                    (cfgThree_q[2:0] == 3'b001) ? (senseHalfGain ? 10'd280 : 10'd140) :
                    10'd0;
  assign windowOk = (cfgThree_q[2:0] == 3'b100) || (cfgThree_q[2:0] == 3'b010) ||
                    (cfgThree_q[2:0] == 3'b001);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      voltWindowMv_q    <= 10'd0;
      voltWindowValid_q <= 1'b0;
    end else begin
      voltWindowMv_q    <= windowMv;
      voltWindowValid_q <= windowOk;
    end
  end

  // ----------------------------------------------------------------
  // Turn-off wait and shutdown sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_OFF  = 2'b00,
    PWR_ON   = 2'b01,
    PWR_WAIT = 2'b10
  } pwr_state_e;

  pwr_state_e  pwr_q;
  logic [8:0]  tickCnt_q;
  logic [15:0] waitCnt_q;
  logic        enFall, tickPulse;
  logic [8:0]  tickLen;
  assign enFall    = (pwr_q == PWR_ON) && !enStable_q[0];
  assign tickLen   = cfgThree_q[CFG_DELAY_TICK_SEL] ? 9'(TICK_SLOW_CYC - 1)
                                                    : 9'(TICK_FAST_CYC - 1);
  assign tickPulse = (pwr_q == PWR_WAIT) && (tickCnt_q == tickLen);

  // A tick divider only runs while waiting, so every wait starts on a whole tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q          <= PWR_OFF;
      tickCnt_q      <= 9'd0;
      waitCnt_q      <= 16'h0000;
      railPowerOn_q  <= 1'b0;
      hiZOff_q       <= 1'b0;
      softOffStart_q <= 1'b0;
      softOffSlew_q  <= 2'b00;
    end else begin
      softOffStart_q <= 1'b0;
      unique case (pwr_q)
        PWR_OFF: begin
          if (enStable_q[0]) begin
            pwr_q         <= PWR_ON;
            railPowerOn_q <= 1'b1;
            hiZOff_q      <= 1'b0;
          end
        end
        PWR_ON: begin
          if (enFall && offMode == OFF_HIZ) begin
            pwr_q         <= PWR_OFF;
            railPowerOn_q <= 1'b0;
            hiZOff_q      <= 1'b1;
          end else if (enFall) begin
            pwr_q     <= PWR_WAIT;
            tickCnt_q <= 9'd0;
            waitCnt_q <= turnOffWait;
          end
        end
        PWR_WAIT: begin
          tickCnt_q <= tickPulse ? 9'd0 : tickCnt_q + 9'd1;
          if (enStable_q[0]) begin
            pwr_q <= PWR_ON; // Enable back before shutdown began
          end else if (waitCnt_q == 16'h0000) begin
            pwr_q          <= PWR_OFF;
            railPowerOn_q  <= 1'b0;
            softOffStart_q <= 1'b1;
            softOffSlew_q  <= offMode;
          end else if (tickPulse) begin
            waitCnt_q <= waitCnt_q - 16'h0001;
          end
        end
        default: pwr_q <= PWR_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shedding exit detection
  // ----------------------------------------------------------------
  logic [7:0] gapLimit, offLimit;
  logic       singleMode, multiMode, offHit, gapHit, offMiss, gapMiss;
  logic [2:0] singleNeed, multiNeed;
  logic       singleExit, multiExit, exitNow;
  logic [2:0] singleCnt_q, multiCnt_q;
  logic [11:0] holdCnt_q;

  assign offLimit = limOneTwo_q[7:0];
  assign gapLimit = (railOnePhases == 3'd2) ? limOneTwo_q[15:8]    :
                    (railOnePhases == 3'd3) ? limThreeFour_q[7:0]  :
                    (railOnePhases == 3'd4) ? limThreeFour_q[15:8] :
                    (railOnePhases == 3'd5) ? limFiveSix_q[7:0]    :
                    (railOnePhases == 3'd6) ? limFiveSix_q[15:8]   :
                    limSeven_q[7:0];
  assign singleMode = shedCtrl_q[CTL_SINGLE_EXIT_ON] && (railOnePhases == 3'd1);
  assign multiMode  = shedCtrl_q[CTL_MULTI_EXIT_ON] && (railOnePhases > 3'd1);
  assign offHit  = singleMode && shedMeas.offValid && (shedMeas.offTime < {2'b00, offLimit});
  assign offMiss = singleMode && shedMeas.offValid && !offHit;
  assign gapHit  = multiMode && shedMeas.gapValid && (shedMeas.gapTime < {2'b00, gapLimit});
  assign gapMiss = multiMode && shedMeas.gapValid && !gapHit;
  // A zero count is read as one hit, the least that can trigger
  assign singleNeed = (shedCtrl_q[9:7] == 3'd0) ? 3'd1 : shedCtrl_q[9:7];
  assign multiNeed  = (shedCtrl_q[2:0] == 3'd0) ? 3'd1 : shedCtrl_q[2:0];
  assign singleExit = offHit && (singleCnt_q + 3'd1 >= singleNeed);
  assign multiExit  = gapHit && (multiCnt_q + 3'd1 >= multiNeed);
  assign exitNow    = !forceFullPhase_q && (singleExit || multiExit);

  // Counters see only runs of hits; they rest while all phases are forced on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      singleCnt_q <= 3'd0;
      multiCnt_q  <= 3'd0;
    end else begin
      if (forceFullPhase_q || exitNow || offMiss || !singleMode) singleCnt_q <= 3'd0;
      else if (offHit) singleCnt_q <= singleCnt_q + 3'd1;
      if (forceFullPhase_q || exitNow || gapMiss || !multiMode) multiCnt_q <= 3'd0;
      else if (gapHit) multiCnt_q <= multiCnt_q + 3'd1;
    end
  end

  // Full-phase hold; a zero hold time still forces all phases for one cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      forceFullPhase_q <= 1'b0;
      holdCnt_q        <= 12'd0;
    end else if (exitNow) begin
      forceFullPhase_q <= 1'b1;
      holdCnt_q        <= 12'(shedCtrl_q[6:3] * HOLD_LSB_CYC);
    end else if (holdCnt_q != 12'd0) begin
      holdCnt_q <= holdCnt_q - 12'd1;
    end else begin
      forceFullPhase_q <= 1'b0;
    end
  end

  // Rail two limit pick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) railTwoGapLimit_q <= 8'h00;
    else railTwoGapLimit_q <= (railTwoPhases == 2'd2) ? limFiveSix_q[15:8] :
                              (railTwoPhases == 2'd3) ? limFiveSix_q[7:0]  :
                              limSeven_q[7:0];
  end

  // ----------------------------------------------------------------
  // Current report and over-current warning
  // ----------------------------------------------------------------
  logic [22:0] product;
  logic        repValid_q, ocwHit;
  assign product = monitorSample * gain_q[10:0];
  assign ocwHit  = repValid_q && (reportCurrent_q > {4'h0, ocwLimit_q[8:0]});

  // Status flags stay set until cleared; a new hit wins over the clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reportCurrent_q <= 13'd0;
      repValid_q      <= 1'b0;
      statusWordOcw_q <= 1'b0;
      statusIoutOcw_q <= 1'b0;
      power_alert_n_q <= 1'b1;
    end else begin
      repValid_q <= monitorValid;
      if (monitorValid) reportCurrent_q <= product[22:GAIN_SHIFT];
      statusWordOcw_q <= ocwHit || (statusWordOcw_q && !ocwClear);
      statusIoutOcw_q <= ocwHit || (statusIoutOcw_q && !ocwClear);
      power_alert_n_q <= !(cfgThree_q[CFG_ALERT_ON_OCW] &&
                           (ocwHit || (statusWordOcw_q && !ocwClear)));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_exit_taken;
    exitNow;
  endsequence
  sequence s_hold_running;
    forceFullPhase_q [*8];
  endsequence

  a_ocw_status_set: assert property (ocwHit |=> statusWordOcw_q && statusIoutOcw_q)
    else $error("warning status not set");
  a_alert_gated: assert property (!cfgThree_q[CFG_ALERT_ON_OCW] |=> power_alert_n_q)
    else $error("alert low while disabled");
  a_alert_follows: assert property (cfgThree_q[CFG_ALERT_ON_OCW] && ocwHit |=> !power_alert_n_q)
    else $error("alert missing on warning");
  a_hold_load: assert property (s_exit_taken |=>
                                holdCnt_q == 12'($past(shedCtrl_q[6:3]) * HOLD_LSB_CYC))
    else $error("hold time wrong");
  a_hold_long: assert property ((s_exit_taken and shedCtrl_q[6:3] != 4'd0) |=> s_hold_running)
    else $error("full phase dropped early");
  a_count_clear: assert property (offMiss && !forceFullPhase_q |=> singleCnt_q == 3'd0)
    else $error("off time counter kept");
  a_single_exit: assert property (singleExit && !forceFullPhase_q |=> forceFullPhase_q)
    else $error("no exit at count");
  a_reserved_zero: assert property (cmdRead && cmdCode == CMD_SHED_EXIT_CTRL |=>
                                    cmdRdData_q[15:12] == 4'h0)
    else $error("reserved bits read back");
  a_sleep_store: assert property (sleepNow |=> !nvStoreOn_q)
    else $error("store left on in sleep");
  a_hiz_off: assert property (enFall && offMode == OFF_HIZ |=> hiZOff_q && !railPowerOn_q)
    else $error("high-Z shutdown missing");
  a_tick_len: assert property (tickPulse && !cfgThree_q[CFG_DELAY_TICK_SEL] |->
                               $past(tickCnt_q) == 9'(TICK_FAST_CYC - 2))
    else $error("tick period wrong");
endmodule

// ===== tb/cmd_host.sv
`timescale 1ns/1ps
// Host model: one command per call, its strobe up for exactly one taking edge
module cmd_host (
  input  wire logic        clk_sys,
  output logic      [7:0]  cmdCode = 8'h00,
  output logic             cmdWrite = 1'b0,
  output logic      [15:0] cmdWrData = 16'h0000,
  output logic             cmdRead = 1'b0,
  input  wire logic [15:0] cmdRdData_q
);
  // Read data stands only in the cycle after the taking edge, so it is caught there
  task automatic xfer(input logic w, logic [7:0] c, logic [15:0] d, output logic [15:0] q);
    @(posedge clk_sys);
    {cmdWrite, cmdRead, cmdCode, cmdWrData} <= {w, !w, c, d};
    @(posedge clk_sys);
    {cmdWrite, cmdRead} <= 2'b00;
    #1;
    q = cmdRdData_q;
  endtask
endmodule

// ===== tb/rail_config_shed_exit_regs_tb.sv
`timescale 1ns/1ps
module rail_config_shed_exit_regs_tb;
  import rail_cfg_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, senseHalfGain = 1'b0, monitorValid = 1'b0;
  logic [11:0] monitorSample = 12'h000;
  shed_meas_s  shedMeas = '0;
  logic [7:0]  cmdCode;
  logic        cmdWrite, cmdRead, cpl, fullPh, wOcw, iOcw, alert_n;
  logic [15:0] cmdWrData, cmdRdData, rdata;
  logic [9:0]  windowMv;
  logic [12:0] report;
  logic [1:0]  enPin = 2'b00, phases2 = 2'd2, slew;
  logic [2:0]  phases1 = 3'd1;
  logic [15:0] offWait = 16'h0000;
  logic        ocwClr = 1'b0, storeOn, portOn, railOn, hiZ, softStart, winOk, rdValid;
  logic [7:0]  gap2;
  int          errors = 0, num_checks = 0;
  rail_config_shed_exit_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cmdCode(cmdCode),
    .cmdWrite(cmdWrite), .cmdWrData(cmdWrData), .cmdRead(cmdRead), .cmdRdData_q(cmdRdData),
    .cmdRdValid_q(rdValid), .enablePin(enPin), .turnOffWait(offWait),
    .senseHalfGain(senseHalfGain), .railOnePhases(phases1), .railTwoPhases(phases2),
    .shedMeas(shedMeas), .ocwClear(ocwClr),
    .monitorValid(monitorValid), .monitorSample(monitorSample), .coupledInductorOn_q(cpl),
    .nvStoreOn_q(storeOn), .commandPortOn_q(portOn), .railPowerOn_q(railOn), .hiZOff_q(hiZ),
    .softOffStart_q(softStart), .softOffSlew_q(slew), .voltWindowMv_q(windowMv),
    .voltWindowValid_q(winOk), .railTwoGapLimit_q(gap2),
    .forceFullPhase_q(fullPh), .reportCurrent_q(report), .statusWordOcw_q(wOcw),
    .statusIoutOcw_q(iOcw), .power_alert_n_q(alert_n));
  cmd_host host_u (.clk_sys(clk_sys), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
    .cmdWrData(cmdWrData), .cmdRead(cmdRead), .cmdRdData_q(cmdRdData));
  // Free-running 100 ns clock
  initial forever #50 clk_sys = ~clk_sys;
  // Three cycles of reset, then the scenarios in an order that reuses earlier settings
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_current();
    t_shed();
    t_limits();
    t_power();
    results();
  end
  // Watchdog far past the roughly seven hundred cycles the scenarios take
  initial begin
    #1000000;
    errors++;
    results();
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp) errors++;
  endtask
  // All-ones write read back through each mask; code 4b is unmapped and reads zero
  task automatic t_regs();
    logic [23:0] tbl [9] = '{24'h44_03ff, 24'h45_0fff, 24'h46_ffff, 24'h47_ffff,
      24'h48_ffff, 24'h49_00ff, 24'h4a_01ff, 24'h4d_07ff, 24'h4b_0000};
    foreach (tbl[i]) begin
      host_u.xfer(1'b1, tbl[i][23:16], 16'hffff, rdata);
      host_u.xfer(1'b0, tbl[i][23:16], 16'h0000, rdata);
      chk(rdata, tbl[i][15:0]);
    end
    chk(16'({rdValid, storeOn, portOn, winOk, windowMv}), 16'h2800);
  endtask
  // Gain 2047 left by the mask test scales the sample; flags, alert and window code follow
  task automatic t_current();
    host_u.xfer(1'b1, 8'h4a, 16'h000a, rdata);
    host_u.xfer(1'b1, 8'h44, 16'h0281, rdata);
    @(posedge clk_sys);
    {senseHalfGain, monitorSample, monitorValid} <= {1'b1, 12'h028, 1'b1};
    @(posedge clk_sys);
    monitorValid <= 1'b0;
    cyc(2);
    chk(16'(report), 16'h004f);
    chk(16'({wOcw, iOcw, alert_n}), 16'h0006);
    chk(16'({winOk, cpl, windowMv}), 16'h0d18);
    @(posedge clk_sys);
    ocwClr <= 1'b1;
    @(posedge clk_sys);
    ocwClr <= 1'b0;
    #1;
    chk(16'({wOcw, iOcw, alert_n}), 16'h0001);
  endtask
  // A miss between hits restarts the count; two hits in a row force all phases
  task automatic t_shed();
    logic [9:0] ot [4] = '{10'h005, 10'h3ff, 10'h005, 10'h005};
    host_u.xfer(1'b1, 8'h45, 16'h0908, rdata);
    foreach (ot[i]) begin
      @(posedge clk_sys);
      shedMeas <= {1'b1, ot[i], 11'h000};
      @(posedge clk_sys);
      shedMeas <= '0;
      cyc(1);
      chk(16'(fullPh), 16'(i / 3));
    end
    cyc(195);
    chk(16'(fullPh), 16'h0001);
    cyc(4);
    chk(16'(fullPh), 16'h0001);
    cyc(1);
    chk(16'(fullPh), 16'h0000);
  endtask
  // Limit bytes picked by phase count on both rails; a zero hold forces one cycle
  task automatic t_limits();
    host_u.xfer(1'b1, 8'h47, 16'h2010, rdata);
    host_u.xfer(1'b1, 8'h48, 16'h3412, rdata);
    host_u.xfer(1'b1, 8'h45, 16'h0401, rdata);
    @(posedge clk_sys);
    {phases1, phases2, shedMeas} <= {3'd3, 2'd3, 12'h001, 10'h010};
    @(posedge clk_sys);
    shedMeas <= {12'h001, 10'h00f};
    #1;
    chk(16'({fullPh, gap2}), 16'h0012);
    @(posedge clk_sys);
    {phases2, shedMeas} <= {2'd2, 22'h000000};
    #1;
    chk(16'({fullPh, gap2}), 16'h0112);
    @(posedge clk_sys);
    phases2 <= 2'd1;
    #1;
    chk(16'({fullPh, gap2}), 16'h0034);
    @(posedge clk_sys);
    #1;
    chk(16'(gap2), 16'h00ff);
  endtask
  // High-Z off first, then a soft-off that waits two fast ticks before its pulse
  task automatic t_power();
    @(posedge clk_sys);
    {enPin, offWait} <= {2'b01, 16'h0002};
    cyc(5);
    chk(16'({cpl, railOn, hiZ}), 16'h0006);
    @(posedge clk_sys);
    enPin <= 2'b00;
    cyc(5);
    chk(16'({railOn, hiZ}), 16'h0001);
    host_u.xfer(1'b1, 8'h44, 16'h0211, rdata);
    @(posedge clk_sys);
    enPin <= 2'b01;
    cyc(5);
    chk(16'({cpl, railOn, hiZ}), 16'h0002);
    @(posedge clk_sys);
    enPin <= 2'b00;
    cyc(405);
    chk(16'({softStart, railOn}), 16'h0001);
    cyc(1);
    chk(16'({softStart, railOn, slew}), 16'h0009);
    cyc(1);
    chk(16'(softStart), 16'h0000);
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
endmodule
